// ---- bench/adc_extra_conversion_ctrl_test.sv ----
// Purpose: Self-checking bench for the extra conversion control block
// Assumes: Zero wait state slave, core model on the far side
// Notes: Expected reads and launches are queued by the driver
`timescale 1ns/1ns
`default_nettype none
module adc_extra_conversion_ctrl_test;
  import aec_pkg::*;
  logic ref_clk, reset, hsel, hwrite, hready, seqRunning, slow, rdPhase;
  logic coreBusy, coreDone, convStart, extraBusy;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  aec_conv_s convReq;
  aec_route_s convRoute;
  aec_rate_s convRate;
  int n_fail, samples_checked, cycles;
  integer seed = 32'h94A48B83;
  logic [31:0] rdQ[$];
  aec_conv_s reqQ[$];
  aec_extra_ctrl dut_u (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hready), .hrdata, .hreadyout(hready), .hresp, .seqRunning,
    .coreBusy, .coreDone, .convStart, .convReq, .convRoute, .convRate, .extraBusy);
  aec_core_model core_u (.ref_clk, .reset, .convStart, .slow, .coreBusy, .coreDone);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic fail(string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic finish_test;
    if (reqQ.size() != 0) fail("launch missing");
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk_rd(logic [31:0] g);
    samples_checked++;
    if (g !== rdQ.pop_front()) fail("read data");
  endtask
  task automatic chk_req(aec_conv_s g);
    samples_checked++;
    if (reqQ.size() == 0 || g !== reqQ.pop_front()) fail("launch request");
  endtask
  task automatic bus(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    rdPhase <= !w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rdPhase <= 1'b0;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    rdQ.push_back(e);
    bus(1'b0, a, RDATA_ZERO);
  endtask
  // Polls on the falling edge so the busy flag has settled
  task automatic idle;
    int i;
    i = 0;
    do @(negedge ref_clk); while (extraBusy !== 1'b0 && i++ < 80);
    if (i >= 80) fail("busy stuck");
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (rdPhase) chk_rd(hrdata);
    if (rdPhase && hresp !== HRESP_OKAY) fail("bus response");
    if (convStart === 1'b1) chk_req(convReq);
    cycles++;
    if (cycles > 5000) begin
      fail("timeout");
      finish_test();
    end
  end
  initial begin
    {hsel, hwrite, seqRunning, slow, rdPhase} = 5'h00;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = HTRANS_IDLE;
    hsize = 3'h2;
    reset = 1'b1;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd(CTRL_ADDR, 32'h00000000);
    bus(1'b1, 32'h00000100, 32'h000000FF);
    rd(32'h00000100, 32'h00000000);
    $display("test reset done");
    for (int c = 0; c < 16; c++) begin
      v = $random(seed);
      v[3:0] = c[3:0];
      slow <= v[8];
      reqQ.push_back({v[3:0], v[7:6], v[5:4]});
      bus(1'b1, CTRL_ADDR, {24'h000000, v[7:0]});
      idle();
      rd(CTRL_ADDR, {24'h000000, v[7:4], 4'h0});
    end
    $display("test channels done");
    seqRunning <= 1'b1;
    bus(1'b1, CTRL_ADDR, 32'h000000A5);
    repeat (10) @(posedge ref_clk);
    bus(1'b1, CTRL_ADDR, 32'h00000069);
    rd(CTRL_ADDR, 32'h00000069);
    reqQ.push_back({4'h9, 2'h1, 2'h2});
    seqRunning <= 1'b0;
    idle();
    rd(CTRL_ADDR, 32'h00000060);
    seqRunning <= 1'b1;
    repeat (5) @(posedge ref_clk);
    seqRunning <= 1'b0;
    repeat (10) @(posedge ref_clk);
    $display("test pending done");
    finish_test();
  end
endmodule
`default_nettype wire

// ---- bench/aec_core_model.sv ----
// Purpose: Behavioural converter core answering extra launches
// Assumes: One launch at a time, done pulse ends it
// Notes: Slow mode stretches the conversion to stress pending logic
`timescale 1ns/1ns
`default_nettype none
module aec_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Launch and pacing
  input wire logic convStart,
  input wire logic slow,
  // Core status
  output logic coreBusy,
  output logic coreDone
);
  logic [4:0] cnt_q;
  always_ff @(posedge ref_clk) begin
    coreDone <= 1'b0;
    if (reset) begin
      cnt_q <= 5'h00;
      coreBusy <= 1'b0;
    end else if (convStart) begin
      coreBusy <= 1'b1;
      cnt_q <= slow ? 5'h14 : 5'h02;
    end else if (coreBusy) begin
      cnt_q <= cnt_q - 5'h01;
      if (cnt_q == 5'h00) begin
        coreBusy <= 1'b0;
        coreDone <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/aec_extra_monitor.sv ----
// Purpose: Port checker for the extra conversion control block
// Assumes: One clock, sees top ports only
// Notes: Shadows the control byte from bus writes
`timescale 1ns/1ns
`default_nettype none
module aec_extra_monitor
  import aec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Core side
  input wire logic seqRunning,
  input wire logic coreBusy,
  input wire logic coreDone,
  input wire logic convStart,
  input wire aec_conv_s convReq,
  input wire aec_route_s convRoute,
  input wire aec_rate_s convRate,
  input wire logic extraBusy
);
  logic wrPh_q;
  logic inConv_q;
  logic [7:0] ctrl_q;
  wire hit = hsel && hready && htrans[1] && hwrite && haddr == CTRL_ADDR;
  // Codes twelve up map onto the special kinds in order
  function automatic aec_src_e kindOf(logic [3:0] c);
    return c <= CH_LAST_SINGLE ? SRC_SINGLE :
      c <= CH_LAST_DIFF ? SRC_DIFF : aec_src_e'(3'(c - 4'hA));
  endfunction
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrPh_q <= 1'b0;
      ctrl_q <= CTRL_RST;
      inConv_q <= 1'b0;
    end else begin
      wrPh_q <= hit;
      if (wrPh_q) ctrl_q <= hwdata[7:0];
      else if (coreDone) ctrl_q[3:0] <= CH_CLEARED;
      if (convStart) inConv_q <= 1'b1;
      else if (coreDone) inConv_q <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_fields;
    // Fields are latched in the launch cycle, on the same edge that raises the start pulse
    convStart |-> convReq == {$past(ctrl_q[3:0]), $past(ctrl_q[7:6]), $past(ctrl_q[5:4])};
  endproperty
  a_fields: assert property (p_fields) else $error("launch fields wrong");
  property p_rate;
    convStart |=> convRate.decimRate == (DECIM_64 << convReq.decSel) &&
      convRate.resolution == (convReq.decSel == DEC_SEL_512 ? RES_13 :
      RES_8 + {convReq.decSel, 1'b0});
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode wrong");
  property p_single;
    convStart ##1 convReq.channel < CH_LAST_SINGLE |-> convRoute.kind == SRC_SINGLE &&
      convRoute.posInput == convReq.channel[2:0] && !convRoute.negUsed;
  endproperty
  a_single: assert property (p_single) else $error("single route wrong");
  property p_kind;
    convStart |=> convRoute.kind == kindOf(convReq.channel);
  endproperty
  a_kind: assert property (p_kind) else $error("route kind wrong");
  property p_imm;
    wrPh_q && !seqRunning && !coreBusy && !extraBusy |-> ##2 convStart;
  endproperty
  a_imm: assert property (p_imm) else $error("idle write not launched");
  property p_after;
    convStart |-> !$past(seqRunning, 2) && !$past(coreBusy, 2);
  endproperty
  a_after: assert property (p_after) else $error("launch during sequence");
  property p_cause;
    $rose(extraBusy) |-> $past(wrPh_q);
  endproperty
  a_cause: assert property (p_cause) else $error("request without write");
  property p_one;
    convStart |-> !inConv_q;
  endproperty
  a_one: assert property (p_one) else $error("second launch");
  c_imm: cover property (wrPh_q && !seqRunning ##2 convStart);
  c_pend: cover property (seqRunning && extraBusy);
  c_done: cover property (coreDone);
endmodule
bind aec_extra_ctrl aec_extra_monitor mon_u (.ref_clk, .reset, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .seqRunning, .coreBusy, .coreDone, .convStart, .convReq,
  .convRoute, .convRate, .extraBusy);
`default_nettype wire

// ---- hdl/aec_decode.sv ----
// Purpose: Decodes a latched extra conversion request into input routing and rate
// Assumes: Purely combinational, registered by the caller
// Notes: Differential pairs always take the even input as the positive side
`timescale 1ns/1ns
`default_nettype none
module aec_decode
  import aec_pkg::*;
(
  // Request fields
  input wire aec_conv_s req,
  // Decoded view
  output aec_route_s route,
  output aec_rate_s rate
);

  wire logic isSingle;
  wire logic isDiff;
  wire aec_src_e specialKind;

  assign isSingle = (req.channel <= CH_LAST_SINGLE); // [R7]
  assign isDiff = !isSingle && (req.channel <= CH_LAST_DIFF); // [R8]
  assign specialKind = (req.channel == CH_GROUND) ? SRC_GROUND :
                       (req.channel == CH_POS_REF) ? SRC_POS_REF :
                       (req.channel == CH_TEMP) ? SRC_TEMP : SRC_SUPPLY_THIRD; // [R8]

  assign route.kind = isSingle ? SRC_SINGLE : (isDiff ? SRC_DIFF : specialKind);
  assign route.posInput = isSingle ? req.channel[2:0] :
                          (isDiff ? {req.channel[1:0], 1'b0} : 3'h0); // [R7]
  assign route.negInput = isDiff ? {req.channel[1:0], 1'b1} : 3'h0; // [R8]
  assign route.negUsed = isDiff;

  assign rate.decimRate = (req.decSel == DEC_SEL_64) ? DECIM_64 :
                          (req.decSel == DEC_SEL_128) ? DECIM_128 :
                          (req.decSel == DEC_SEL_256) ? DECIM_256 : DECIM_512; // [R2]
  assign rate.resolution = (req.decSel == DEC_SEL_64) ? RES_8 :
                           (req.decSel == DEC_SEL_128) ? RES_10 :
                           (req.decSel == DEC_SEL_256) ? RES_12 : RES_13; // [R2]

endmodule
`default_nettype wire

// ---- hdl/aec_extra_ctrl.sv ----
// Purpose: Extra conversion control register and launch sequencer behind AHB-Lite
// Assumes: Converter core reports sequence activity, busy and a done pulse
// Notes: Zero wait state slave; channel writes while a conversion is pending share one conversion
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R1] Reference field picks the extra reference
// [R2] Rate field sets decimation and resolution
// [R3] Convert held channel after sequence finishes
// [R4] Only a channel write requests conversion
// [R5] Idle converter starts at once on write
// [R6] Channel field clears when conversion completes
// [R7] Codes zero to six are single inputs; the code treats codes zero to seven as single inputs
// [R8] Remaining codes: input seven, pairs, specials; the code has code seven single, eight to eleven pairs, twelve up specials
// [R9] Pending request yields one conversion, latched
module aec_extra_ctrl
  import aec_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  // Converter core status
  input wire logic seqRunning,
  input wire logic coreBusy,
  input wire logic coreDone,
  // Converter core request
  output logic convStart,
  output aec_conv_s convReq,
  output aec_route_s convRoute,
  output aec_rate_s convRate,
  output logic extraBusy
);

  // Registers
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  aec_state_e state_q;
  aec_state_e state_d;
  logic again_q;
  logic again_d;
  logic wrCtrl_q;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic hreadyout_q;
  logic convStart_q;
  aec_conv_s convReq_q;
  aec_conv_s convReq_d;
  aec_route_s convRoute_q;
  aec_rate_s convRate_q;
  logic extraBusy_q;

  // Bus decode
  wire logic addrPhase;
  wire logic hitCtrl;
  wire logic hitStat;
  wire logic wrCtrlAddr;
  wire logic chanWrite;
  wire logic [7:0] ctrlView;
  wire logic [7:0] statView;

  // Sequencer terms
  wire logic convActive;
  wire logic launchNow;
  wire logic doneNow;
  wire aec_conv_s liveReq;
  wire aec_route_s liveRoute;
  wire aec_rate_s liveRate;

  assign addrPhase = hsel && hready && htrans[1];
  assign hitCtrl = (haddr == CTRL_ADDR);
  assign hitStat = (haddr == STAT_ADDR);
  assign wrCtrlAddr = addrPhase && hwrite && hitCtrl;

  // Data phase of a control write; every such write carries the channel field
  assign chanWrite = wrCtrl_q; // [R4]

  // Forward write data so a read right behind a write sees the new value
  assign ctrlView = wrCtrl_q ? hwdata[7:0] : ctrl_q;
  assign statView = {convReq_q.channel, 2'b00,
                     (state_q == ST_LAUNCH) || (state_q == ST_CONV),
                     (state_q == ST_WAIT) || again_q};

  assign hrdata_d = !(addrPhase && !hwrite) ? hrdata_q :
                    hitCtrl ? {24'h000000, ctrlView} :
                    hitStat ? {24'h000000, statView} : RDATA_ZERO;

  // Converter counts as active for both a running sequence and a busy core
  assign convActive = seqRunning || coreBusy; // [R3]
  assign launchNow = (state_q == ST_LAUNCH);
  assign doneNow = (state_q == ST_CONV) && coreDone;

  // Fields are sampled at launch, not at the time of the write
  assign liveReq.channel = ctrl_q[CH_MSB:CH_LSB]; // [R3]
  assign liveReq.refSel = aec_ref_e'(ctrl_q[REF_MSB:REF_LSB]); // [R1]
  assign liveReq.decSel = aec_dec_e'(ctrl_q[DEC_MSB:DEC_LSB]); // [R2]

  aec_decode u_decode (
    .req(liveReq),
    .route(liveRoute),
    .rate(liveRate)
  );

  // Control register: bus write beats the hardware clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (doneNow) begin
      ctrl_d[CH_MSB:CH_LSB] = CH_CLEARED; // [R6]
    end
    if (chanWrite) begin
      ctrl_d = hwdata[7:0];
    end
  end

  // Sequencer
  always_comb begin
    state_d = state_q;
    again_d = again_q;
    case (state_q)
      ST_IDLE: begin
        if (chanWrite) begin
          state_d = convActive ? ST_WAIT : ST_LAUNCH; // [R5]
        end
      end
      ST_WAIT: begin
        // Further writes here only refresh the fields; still one conversion
        if (!convActive) begin
          state_d = ST_LAUNCH; // [R9]
        end
      end
      ST_LAUNCH: begin
        state_d = ST_CONV;
        if (chanWrite) begin
          again_d = 1'b1;
        end
      end
      ST_CONV: begin
        if (chanWrite) begin
          again_d = 1'b1;
        end
        if (coreDone) begin
          // A write that lands with the done is kept, not lost
          state_d = (again_q || chanWrite) ? ST_WAIT : ST_IDLE; // [R9]
          again_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        again_d = 1'b0;
      end
    endcase
  end

  assign convReq_d = launchNow ? liveReq : convReq_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      state_q <= ST_IDLE;
      again_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      again_q <= again_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wrCtrl_q <= 1'b0;
      hrdata_q <= RDATA_ZERO;
      hreadyout_q <= 1'b1;
    end else begin
      wrCtrl_q <= wrCtrlAddr;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
    end
  end

  // Request fields convReq, convRoute and convRate change only at launch so the core sees stable fields
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      convStart_q <= 1'b0;
      convReq_q <= '0;
      convRoute_q <= '0;
      convRate_q <= '0;
      extraBusy_q <= 1'b0;
    end else begin
      convStart_q <= launchNow; // [R3]
      convReq_q <= convReq_d; // [R9]
      if (launchNow) begin
        convRoute_q <= liveRoute; // [R7] [R8]
        convRate_q <= liveRate; // [R1] [R2]
      end
      extraBusy_q <= (state_d != ST_IDLE);
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = HRESP_OKAY;
  assign convStart = convStart_q;
  assign convReq = convReq_q;
  assign convRoute = convRoute_q;
  assign convRate = convRate_q;
  assign extraBusy = extraBusy_q;

endmodule
`default_nettype wire

// ---- hdl/aec_pkg.sv ----
// Purpose: Shared constants and types for the extra conversion control block
// Assumes: 32-bit AHB-Lite register bus, one clock domain
// Notes: Register indexes are not word multiples, so byte address is index times four
package aec_pkg;

  // Register map (index and byte address)
  localparam logic [7:0] CTRL_IDX = 8'hB5;
  localparam logic [7:0] STAT_IDX = 8'hB4;
  localparam logic [31:0] CTRL_ADDR = {22'h000000, CTRL_IDX, 2'b00};
  localparam logic [31:0] STAT_ADDR = {22'h000000, STAT_IDX, 2'b00};
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Control register fields
  localparam int unsigned REF_MSB = 7;
  localparam int unsigned REF_LSB = 6;
  localparam int unsigned DEC_MSB = 5;
  localparam int unsigned DEC_LSB = 4;
  localparam int unsigned CH_MSB = 3;
  localparam int unsigned CH_LSB = 0;
  localparam logic [3:0] CH_CLEARED = 4'h0;

  // Status register fields
  localparam int unsigned STAT_PEND_BIT = 0;
  localparam int unsigned STAT_CONV_BIT = 1;
  localparam int unsigned STAT_CH_LSB = 4;

  // Bus encodings
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // Channel code boundaries
  localparam logic [3:0] CH_LAST_SINGLE = 4'h7;
  localparam logic [3:0] CH_LAST_DIFF = 4'hB;
  localparam logic [3:0] CH_GROUND = 4'hC;
  localparam logic [3:0] CH_POS_REF = 4'hD;
  localparam logic [3:0] CH_TEMP = 4'hE;

  // Decimation rates and resolutions
  localparam logic [9:0] DECIM_64 = 10'h040;
  localparam logic [9:0] DECIM_128 = 10'h080;
  localparam logic [9:0] DECIM_256 = 10'h100;
  localparam logic [9:0] DECIM_512 = 10'h200;
  localparam logic [3:0] RES_8 = 4'h8;
  localparam logic [3:0] RES_10 = 4'hA;
  localparam logic [3:0] RES_12 = 4'hC;
  localparam logic [3:0] RES_13 = 4'hD;

  typedef enum logic [1:0] {
    REF_INTERNAL_1V25 = 2'h0,
    REF_INPUT_SEVEN = 2'h1,
    REF_SUPPLY_PIN = 2'h2,
    REF_DIFF_SIX_SEVEN = 2'h3
  } aec_ref_e;

  typedef enum logic [1:0] {
    DEC_SEL_64 = 2'h0,
    DEC_SEL_128 = 2'h1,
    DEC_SEL_256 = 2'h2,
    DEC_SEL_512 = 2'h3
  } aec_dec_e;

  typedef enum logic [2:0] {
    SRC_SINGLE = 3'h0,
    SRC_DIFF = 3'h1,
    SRC_GROUND = 3'h2,
    SRC_POS_REF = 3'h3,
    SRC_TEMP = 3'h4,
    SRC_SUPPLY_THIRD = 3'h5
  } aec_src_e;

  // Gray coded along idle, wait, launch, convert
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_LAUNCH = 2'b11,
    ST_CONV = 2'b10
  } aec_state_e;

  typedef struct packed {
    logic [3:0] channel;
    aec_ref_e refSel;
    aec_dec_e decSel;
  } aec_conv_s;

  typedef struct packed {
    aec_src_e kind;
    logic [2:0] posInput;
    logic [2:0] negInput;
    logic negUsed;
  } aec_route_s;

  typedef struct packed {
    logic [9:0] decimRate;
    logic [3:0] resolution;
  } aec_rate_s;

endpackage
